// >>> core/incremental_adc_sequencer.sv
// Sequencer, counters and register slave of the incremental ADC
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_cfg.svh"
module incremental_adc_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic column_comparator,
  output logic integ_phi1,
  output logic integ_phi2,
  output logic input_acquire,
  output logic integ_reset,
  output logic timer_irq,
  output logic counter_irq,
  output logic data_available,
  output logic irq,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ============================================================
  // State
  seq_reg_t r_q;
  seq_reg_t r_d;
  logic cmp_pos;
  logic tmr_wrap;
  logic counting;
  logic [15:0] acc_inc;
  logic [15:0] code_wide;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  logic avail_clr;
  logic wr_go;
  logic rd_go;
  logic [4:0] rd_addr;

  // ============================================================
  // Outputs
  // Both integrator phases derive from the same clock as the counters
  assign integ_phi1 = ~r_q.phase;
  assign integ_phi2 = r_q.phase;
  // Phase select swaps the acquiring phase for sources that auto-zero
  assign input_acquire = r_q.ctrl[`CTRL_PHASE] ? r_q.phase :
                         ~r_q.phase;
  assign integ_reset = (r_q.st == ST_RESET);
  assign timer_irq = r_q.sts[`EVT_TIMER] & r_q.mask[`EVT_TIMER];
  assign counter_irq = r_q.sts[`EVT_COUNTER] &
                       r_q.mask[`EVT_COUNTER];
  assign irq = |(r_q.sts & r_q.mask);
  assign data_available = r_q.avail;
  assign s_axi_awready = ~r_q.aw_ok & ~r_q.bvalid;
  assign s_axi_wready = ~r_q.w_ok & ~r_q.bvalid;
  assign s_axi_bvalid = r_q.bvalid;
  assign s_axi_bresp = r_q.bresp;
  assign s_axi_arready = ~r_q.rvalid;
  assign s_axi_rvalid = r_q.rvalid;
  assign s_axi_rdata = r_q.rdata;
  assign s_axi_rresp = r_q.rresp;

  // ============================================================
  // Helpers
  // Only the second synchroniser stage is ever looked at
  assign cmp_pos = r_q.cmp_sync[1];
  assign tmr_wrap = r_q.ctrl[`CTRL_ENABLE] &&
                    (r_q.tmr == `PERIOD_LAST);
  assign counting = (r_q.st == ST_ACCUM) || (r_q.st == ST_WAIT);
  // Saturate instead of wrapping if a late service piles on counts
  assign acc_inc = (r_q.acc == 16'hFFFF) ? r_q.acc :
                   r_q.acc + 16'h0001;
  // Quarter counts per clock: drop two bits, then recentre on midscale
  assign code_wide = {2'h0, r_q.acc[15:2]} - `CODE_MID;
  assign wr_go = r_q.aw_ok & r_q.w_ok & ~r_q.bvalid;
  assign rd_go = s_axi_arvalid & ~r_q.rvalid;
  assign rd_addr = s_axi_araddr[4:0];

  // ============================================================
  // Next state
  always_comb begin
    r_d = r_q;
    evt_set = 3'h0;
    evt_clr = 3'h0;
    avail_clr = 1'b0;
    r_d.cmp_sync = {r_q.cmp_sync[0], column_comparator};
    r_d.phase = ~r_q.phase;

    // Period timer: low 8 bits only, software extends beyond
    if (r_q.ctrl[`CTRL_ENABLE]) begin
      r_d.tmr = r_q.tmr + 8'h01;
    end else begin
      r_d.tmr = 8'h00;
    end
    if (tmr_wrap) begin
      evt_set[`EVT_TIMER] = 1'b1;
    end

    // Positive counter accumulates one quarter count per positive clock
    if (counting && cmp_pos) begin
      r_d.acc = acc_inc;
      if (r_q.acc[7:0] == 8'hFF) begin
        evt_set[`EVT_COUNTER] = 1'b1;
      end
    end

    case (r_q.st)
      ST_IDLE: begin
        r_d.acc = 16'h0000;
        r_d.period = 7'h00;
        if (r_q.ctrl[`CTRL_ENABLE]) begin
          r_d.st = ST_ACCUM;
          r_d.tmr = 8'h00;
        end
      end
      ST_ACCUM: begin
        if (!r_q.ctrl[`CTRL_ENABLE]) begin
          r_d.st = ST_IDLE;
        end else if (tmr_wrap) begin
          r_d.period = r_q.period + 7'h01;
          if (r_q.period == `WINDOW_LAST) begin
            r_d.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Counting goes on until software services the timer request;
        // every cycle of latency here adds spurious counts
        if (!r_q.ctrl[`CTRL_ENABLE]) begin
          r_d.st = ST_IDLE;
        end else if (!r_q.sts[`EVT_TIMER]) begin
          r_d.st = ST_RESET;
          r_d.tmr = 8'h00;
          r_d.avail = 1'b1;
          evt_set[`EVT_DATA] = 1'b1;
          if (code_wide[15]) begin
            r_d.result = code_wide[11:0];
          end else if (code_wide > {4'h0, `CODE_MAX}) begin
            r_d.result = `CODE_MAX;
          end else begin
            r_d.result = code_wide[11:0];
          end
        end
      end
      ST_RESET: begin
        r_d.acc = 16'h0000;
        r_d.period = 7'h00;
        if (!r_q.ctrl[`CTRL_ENABLE]) begin
          r_d.st = ST_IDLE;
        end else if (tmr_wrap) begin
          r_d.st = ST_ACCUM;
        end
      end
      default: begin
        r_d.st = ST_IDLE;
      end
    endcase

    // ----- Write channel: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_d.aw_ok = 1'b1;
      r_d.aw_addr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_d.w_ok = 1'b1;
      r_d.wdata = s_axi_wdata[7:0];
      r_d.wstrb0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      r_d.aw_ok = 1'b0;
      r_d.w_ok = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp = `RESP_OKAY;
      case (r_q.aw_addr)
        `OFS_CTRL: begin
          if (r_q.wstrb0) begin
            r_d.ctrl = r_q.wdata[1:0];
          end
        end
        `OFS_STATUS: begin
          if (r_q.wstrb0) begin
            evt_clr = r_q.wdata[2:0];
          end
        end
        `OFS_MASK: begin
          if (r_q.wstrb0) begin
            r_d.mask = r_q.wdata[2:0];
          end
        end
        `OFS_RESULT: begin
        end
        `OFS_COUNT: begin
        end
        default: begin
          r_d.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end

    // ----- Read channel: answer one cycle after the address is taken
    if (rd_go) begin
      r_d.rvalid = 1'b1;
      r_d.rresp = `RESP_OKAY;
      r_d.rdata = 32'h0000_0000;
      case (rd_addr)
        `OFS_CTRL: begin
          r_d.rdata[1:0] = r_q.ctrl;
        end
        `OFS_STATUS: begin
          r_d.rdata[2:0] = r_q.sts;
          r_d.rdata[3] = r_q.avail;
          r_d.rdata[5:4] = r_q.st;
        end
        `OFS_MASK: begin
          r_d.rdata[2:0] = r_q.mask;
        end
        `OFS_RESULT: begin
          // Sign extended so software sees the two's complement code
          r_d.rdata = {{20{r_q.result[11]}}, r_q.result};
          avail_clr = 1'b1;
        end
        `OFS_COUNT: begin
          r_d.rdata = {1'b0, r_q.period, r_q.acc, r_q.tmr};
        end
        default: begin
          r_d.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end

    // ----- Sticky flags: a set in the clearing cycle wins
    r_d.sts = (r_q.sts & ~evt_clr) | evt_set;
    if (avail_clr && !evt_set[`EVT_DATA]) begin
      r_d.avail = 1'b0;
    end
  end

  // ============================================================
  // Register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.ctrl <= `CTRL_RESET;
      r_q.mask <= `MASK_RESET;
      r_q.bresp <= `RESP_OKAY;
      r_q.rresp <= `RESP_OKAY;
    end else begin
      r_q <= r_d;
    end
  end

endmodule
`default_nettype wire

// >>> inc/adc_seq_cfg.svh
// Offsets, field positions, reset values and counts of the ADC sequencer
// ============================================================
// Operation
// - Timer raises a request every 256 data clocks; each is one period.
// - Counter accumulates comparator-positive clocks over 64 consecutive periods.
// - One more period resets the integrator and forms the result.
// - Accumulation window is 64 times 256 data clocks plus the wait until the timer request is serviced.
// - Timer, counter and integrator phases all run from one clock.
// - Input acquired on phase one; phase select swaps to phase two.
// - Out-of-range input saturates to maximum positive or negative code.
// - Each positive clock adds a quarter count; total is divided by four.
// - Accumulation ends only once the timer request has been serviced.
// - Timer and counter each raise their own interrupt request.
// - Comparator is taken from the block's own dedicated column input.
// - Counter advances while comparator positive, with 16 bits of range.
// - Low 8 bits of timer are hardware, upper bits extended; counter has all 16 bits in hardware.
// - Counter enabled from first period until the timer request after the 64th is serviced, then held reset.
// - Reset period shifts count right by two and sets data-available.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// ============================================================
// Register byte offsets
`define OFS_CTRL 5'h00
`define OFS_STATUS 5'h04
`define OFS_MASK 5'h08
`define OFS_RESULT 5'h0C
`define OFS_COUNT 5'h10
// ============================================================
// Field positions
`define CTRL_ENABLE 0
`define CTRL_PHASE 1
`define EVT_TIMER 0
`define EVT_COUNTER 1
`define EVT_DATA 2
// ============================================================
// Reset values and counts
`define CTRL_RESET 2'h0
`define MASK_RESET 3'h0
`define PERIOD_LAST 8'hFF
`define WINDOW_LAST 7'h3F
`define CODE_MID 16'h0800
`define CODE_MAX 12'h7FF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> inc/adc_seq_pkg.sv
// Types of the ADC sequencer
package adc_seq_pkg;
  // ============================================================
  // Sequence states, Gray along idle-accumulate-wait-reset
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACCUM = 2'h1,
    ST_WAIT = 2'h3,
    ST_RESET = 2'h2
  } seq_state_t;
  // ============================================================
  // Whole state of the sequencer
  typedef struct packed {
    seq_state_t st;
    logic [7:0] tmr;
    logic [6:0] period;
    logic [15:0] acc;
    logic phase;
    logic [1:0] cmp_sync;
    logic [1:0] ctrl;
    logic [2:0] sts;
    logic [2:0] mask;
    logic avail;
    logic [11:0] result;
    logic aw_ok;
    logic [4:0] aw_addr;
    logic w_ok;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_reg_t;
endpackage

// >>> tb/adc_cmp_model.sv
// Column comparator model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_cmp_model (
  input wire logic clk_sys,
  input wire logic cmp_high,
  output logic column_comparator
);
  // ==========
  // Comparator level
  // Registered so the level only moves on the sampling edge
  always_ff @(posedge clk_sys) begin
    column_comparator <= cmp_high;
  end
endmodule
`default_nettype wire

// >>> tb/adc_seq_sva.sv
// Port assertions of the ADC sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic integ_phi1,
  input wire logic integ_phi2,
  input wire logic integ_reset,
  input wire logic timer_irq,
  input wire logic counter_irq,
  input wire logic data_available,
  input wire logic irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  // ==========
  // Run counters, since 256 cycles is far past a repetition
  localparam int WIN = 16384;
  localparam int WIN_MAX = 16640;
  logic [15:0] rcnt_q;
  logic [15:0] wcnt_q;
  logic seen_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rcnt_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      rcnt_q <= integ_reset ? rcnt_q + 16'h0001 : 16'h0000;
      wcnt_q <= integ_reset ? 16'h0000 : wcnt_q + 16'h0001;
      seen_q <= seen_q | integ_reset;
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_phase_pair: assert property (integ_phi2 == !integ_phi1)
    else $error("phases overlap");
  a_phase_step: assert property (
    1'b1 |=> integ_phi1 != $past(integ_phi1))
    else $error("phase stuck");
  a_reset_len: assert property (
    $fell(integ_reset) |-> rcnt_q == 16'h0100)
    else $error("reset period length");
  a_window_len: assert property (
    $rose(integ_reset) && seen_q |-> wcnt_q >= WIN && wcnt_q <= WIN_MAX)
    else $error("window length");
  a_avail_set: assert property (
    $rose(integ_reset) |-> ##[0:1] data_available)
    else $error("data flag not set");
  a_avail_hold: assert property (
    data_available && !s_axi_arvalid && !s_axi_rvalid |=> data_available)
    else $error("data flag lost");
  a_irq_any: assert property (
    timer_irq || counter_irq |-> irq)
    else $error("irq missing");
  // Address and data are held one cycle before the response is raised
  a_wr_resp: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("no write response");
  a_rd_resp: assert property (rd_taken |=> s_axi_rvalid)
    else $error("no read response");
endmodule
bind incremental_adc_sequencer adc_seq_sva u_sva (.*);
`default_nettype wire

// >>> tb/test_incremental_adc_sequencer.sv
// Testbench of the ADC sequencer
`timescale 1ns/10ps
`default_nettype none
module test_incremental_adc_sequencer;
  import adc_seq_pkg::*;
  logic clk_sys, rst, cmp_high, column_comparator;
  logic integ_phi1, integ_phi2, input_acquire, integ_reset;
  logic timer_irq, counter_irq, data_available, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int error_cnt = 0;
  int checks = 0;
  incremental_adc_sequencer u_dut (.*);
  adc_cmp_model u_cmp (.*);
  // ==========
  // Bus and compare tasks
  // One 25 MHz data clock, well above the minimum data clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // ==========
  // Scenarios
  task automatic t_regs();
    logic [1:0] r;
    rd_chk(32'h0, 32'h0, 2'h0);
    rd_chk(32'h8, 32'h0, 2'h0);
    rd_chk(32'h14, 32'h0, 2'h2);
    wr(32'h14, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    wr(32'h8, 32'h7, r);
    rd_chk(32'h8, 32'h7, 2'h0);
  endtask
  task automatic t_phase();
    logic [1:0] r;
    chk({31'h0, input_acquire}, {31'h0, integ_phi1});
    wr(32'h0, 32'h2, r);
    @(posedge clk_sys);
    chk({31'h0, input_acquire}, {31'h0, integ_phi2});
    wr(32'h0, 32'h0, r);
  endtask
  // Services every request like the core; a late clear stretches the window
  task automatic t_conv(input logic hi, input logic [31:0] res);
    logic [31:0] d;
    logic [1:0] r;
    int t;
    int c;
    int k;
    t = 0;
    c = 0;
    cmp_high <= hi;
    for (k = 0; k < 20000 && data_available !== 1'b1; k++) begin
      if (irq === 1'b1) begin
        rd(32'h4, d, r);
        t += int'(d[0]);
        c += int'(d[1]);
        // Timer and counter events are cleared in one short handler
        wr(32'h4, {29'h0, d[2:0]}, r);
      end else @(posedge clk_sys);
    end
    if (hi) begin
      chk(t, 64);
      chk({31'h0, c > 62}, 32'h1);
    end
    rd_chk(32'hC, res, 2'h0);
    @(posedge clk_sys);
    chk({31'h0, data_available}, 32'h0);
  endtask
  task automatic t_mask();
    logic [1:0] r;
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, timer_irq}, 32'h0);
    chk({31'h0, counter_irq}, 32'h0);
    wr(32'h8, 32'h0, r);
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(32'h4, 32'h7, r);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    logic [1:0] r;
    rst = 1'b1;
    cmp_high = 1'b1;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_phase();
    wr(32'h0, 32'h1, r);
    t_conv(1'b1, 32'h000007FF);
    t_conv(1'b0, 32'hFFFFF800);
    t_mask();
    tally_and_finish();
  end
  initial begin
    repeat (50000) @(posedge clk_sys);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
